// >>> core/e1_los_detect.sv
// Loss-of-signal detector working on recovered bit intervals.
module e1_los_detect (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic bit_tick,
    input  wire logic mark,
    input  wire logic etsi_select,
    output logic      los_r
);

    logic [11:0] zero_run_r;
    logic [11:0] zero_run_nxt;
    logic [31:0] window_r;
    logic [31:0] window_nxt;
    logic [5:0]  since_run_r;
    logic [11:0] los_limit;

    function automatic logic [5:0] count_marks(input logic [31:0] w);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + 6'(w[i]);
        end
        return n;
    endfunction

    assign los_limit    = etsi_select ? e1_rx_pkg::LOS_ETSI_ZEROS
                                      : e1_rx_pkg::LOS_G775_ZEROS;
    assign zero_run_nxt = mark ? 12'h000
                        : (zero_run_r == e1_rx_pkg::LOS_ETSI_ZEROS) ? zero_run_r
                        : zero_run_r + 12'h001;
    assign window_nxt   = {window_r[30:0], mark};

    // ****************************************************************
    // Zero run and density window
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_run_r  <= 12'h000;
            window_r    <= 32'h0000_0000;
            since_run_r <= 6'h00;
        end else if (clk_en && bit_tick) begin
            zero_run_r <= zero_run_nxt;
            window_r   <= window_nxt;
            if (zero_run_nxt >= e1_rx_pkg::LOS_RUN_LIMIT) begin
                since_run_r <= 6'h00;
            end else if (since_run_r != e1_rx_pkg::LOS_WIN_BITS) begin
                since_run_r <= since_run_r + 6'h01;
            end
        end
    end

    // ****************************************************************
    // Declare and clear
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            los_r <= 1'b0;
        end else if (clk_en && bit_tick) begin
            if (zero_run_nxt >= los_limit) begin
                los_r <= 1'b1;
            end else if (los_r && count_marks(window_nxt) >= e1_rx_pkg::LOS_CLR_MARKS
                         && since_run_r == e1_rx_pkg::LOS_WIN_BITS) begin
                los_r <= 1'b0;
            end
        end
    end

endmodule // e1_los_detect

// >>> core/e1_rx_channel.sv
// System-side receive logic of one E1 line interface channel.
//
// Contract
// - Three modes: single rail recovered, dual rail recovered, dual rail raw slice.
// - Without configuration the channel runs dual rail with clock recovery.
// - Raw mode drives slicer rails and their exclusive-OR as clock.
// - Negative transmit rail high over 16 transmit clocks selects single rail 1.
// - Host mode, single rail bit 1, raw bit 0 selects single rail 2.
// - Running master clock gives dual rail unless single rail or raw slice is selected; master clock low powers down.
// - Master clock held high forces raw slice and ignores raw bits.
// - Raw bit 0 recovers clock and data; 1 bypasses recovery.
// - Edge select high: outputs change on rising clock; low: falling.
// - Recovered outputs active high; raw rail polarity follows edge select.
// - Transmit inputs are sampled on falling transmit clock edges.
// - Recovery loop runs at sixteen times line rate, 32.768 MHz.
// - Global line rule: 0 selects HDB3, 1 selects AMI.
// - Single rail bit set lets the channel line rule override global.
// - Dual rail bypasses the decoder and ignores line rule settings.
// - Single rail flags received code violations on the violation output.
// - Loss drives the loss output high and reports status changes.
// - Host mode selects loss standard; hardware mode uses the short one.
// - Loss with alarm ones, except in power down: rails all ones, clock replaced by master clock.
// - Single rail decodes to one data pin; dual rail presents NRZ rails.
// - Loss, alarm, violation and zero status changes are individually enabled.
// - Loss after 32 or 2048 zeros; clears on 4 marks, runs under 16.
// - AMI decoding reports bipolar violations only.
module e1_rx_channel (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    input  wire logic                 mclk,
    input  wire logic                 tx_line_clock,
    input  wire logic                 tx_neg_rail,
    input  wire logic                 rx_slice_pos,
    input  wire logic                 rx_slice_neg,
    input  wire e1_rx_pkg::chan_cfg_s cfg,
    input  wire e1_rx_pkg::status_s   irq_enable,
    output logic                      rx_pos_rail,
    output logic                      rx_neg_rail,
    output logic                      rx_recovered_clock,
    output logic                      rx_single_data,
    output logic                      violation_flag_out,
    output logic                      signal_loss_out,
    output e1_rx_pkg::rx_mode_e       rx_mode,
    output e1_rx_pkg::status_s        status,
    output e1_rx_pkg::status_s        status_evt
);

    // ****************************************************************
    // Transmit clock domain: single rail 1 detection
    // ****************************************************************
    logic [4:0] high_cnt_r;
    logic [4:0] high_cnt_nxt;
    logic       sr1_tx_r;

    assign high_cnt_nxt = (high_cnt_r == e1_rx_pkg::SR1_CNT_MAX) ? high_cnt_r
                        : high_cnt_r + 5'h01;

    always_ff @(negedge tx_line_clock or posedge sys_rst) begin
        if (sys_rst) begin
            high_cnt_r <= 5'h00;
            sr1_tx_r   <= 1'b0;
        end else if (!tx_neg_rail) begin
            high_cnt_r <= 5'h00;
            sr1_tx_r   <= 1'b0;
        end else begin
            high_cnt_r <= high_cnt_nxt;
            sr1_tx_r   <= high_cnt_nxt > e1_rx_pkg::SR1_HIGH_LIMIT;
        end
    end

    // ****************************************************************
    // Synchronisers into the system clock domain
    // ****************************************************************
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic       sr1_s;
    logic       mclk_s;
    logic       pos_s;
    logic       neg_s;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
        end else if (clk_en) begin
            meta_r <= {sr1_tx_r, mclk, rx_slice_pos, rx_slice_neg};
            sync_r <= meta_r;
        end
    end

    assign sr1_s  = sync_r[3];
    assign mclk_s = sync_r[2];
    assign pos_s  = sync_r[1];
    assign neg_s  = sync_r[0];

    // ****************************************************************
    // Master clock activity
    // ****************************************************************
    logic       mclk_prev_r;
    logic [7:0] idle_cnt_r;
    logic       mclk_running;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mclk_prev_r <= 1'b0;
            idle_cnt_r  <= e1_rx_pkg::MCLK_TIMEOUT;
        end else if (clk_en) begin
            mclk_prev_r <= mclk_s;
            if (mclk_s != mclk_prev_r) begin
                idle_cnt_r <= 8'h00;
            end else if (idle_cnt_r != e1_rx_pkg::MCLK_TIMEOUT) begin
                idle_cnt_r <= idle_cnt_r + 8'h01;
            end
        end
    end

    assign mclk_running = idle_cnt_r != e1_rx_pkg::MCLK_TIMEOUT;

    // ****************************************************************
    // Mode selection
    // ****************************************************************
    e1_rx_pkg::rx_mode_e mode_r;
    e1_rx_pkg::rx_mode_e mode_nxt;

    always_comb begin
        if (!mclk_running && mclk_s) begin
            mode_nxt = e1_rx_pkg::MODE_DR_RAW;
        end else if (!mclk_running) begin
            mode_nxt = e1_rx_pkg::MODE_PD;
        end else if (sr1_s) begin
            mode_nxt = e1_rx_pkg::MODE_SR1;
        end else if (cfg.host_mode && cfg.channel_raw_slice_bit) begin
            mode_nxt = e1_rx_pkg::MODE_DR_RAW;
        end else if (cfg.host_mode && cfg.channel_single_rail_bit) begin
            mode_nxt = e1_rx_pkg::MODE_SR2;
        end else begin
            mode_nxt = e1_rx_pkg::MODE_DR_CR;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= e1_rx_pkg::MODE_DR_CR;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
        end
    end

    // ****************************************************************
    // Oversampling phase loop
    // ****************************************************************
    logic [15:0] acc_r;
    logic [15:0] acc_nxt;
    logic        os_tick;
    logic [3:0]  phase_r;
    logic        mark_prev_r;
    logic        pos_seen_r;
    logic        neg_seen_r;
    logic        bit_tick;
    logic        bit_pos;
    logic        bit_neg;

    assign {os_tick, acc_nxt} = {1'b0, acc_r} + {1'b0, e1_rx_pkg::OS_INC};
    assign bit_tick = os_tick && phase_r == e1_rx_pkg::SAMPLE_PHASE;
    assign bit_pos  = pos_seen_r | pos_s;
    assign bit_neg  = neg_seen_r | neg_s;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r       <= 16'h0000;
            phase_r     <= 4'h0;
            mark_prev_r <= 1'b0;
        end else if (clk_en) begin
            acc_r <= acc_nxt;
            if (os_tick) begin
                mark_prev_r <= pos_s | neg_s;
                if ((pos_s | neg_s) && !mark_prev_r) begin
                    phase_r <= e1_rx_pkg::REALIGN_PHASE;
                end else begin
                    phase_r <= phase_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_seen_r <= 1'b0;
            neg_seen_r <= 1'b0;
        end else if (clk_en && os_tick) begin
            pos_seen_r <= bit_tick ? 1'b0 : bit_pos;
            neg_seen_r <= bit_tick ? 1'b0 : bit_neg;
        end
    end

    // ****************************************************************
    // HDB3 and AMI decoder
    // ****************************************************************
    logic       ami_sel;
    logic       bit_mark;
    logic       last_pol_r;
    logic       any_mark_r;
    logic [1:0] hist_r;
    logic [2:0] zero_cnt_r;
    logic [3:0] data_dly_r;
    logic [3:0] cv_dly_r;
    logic       dr_pos_r;
    logic       dr_neg_r;
    logic       bpv;
    logic       subst;
    logic       exz;
    logic       cv_now;

    assign ami_sel  = (cfg.host_mode && cfg.channel_single_rail_bit)
                    ? cfg.channel_ami_select
                    : cfg.global_ami_select;
    assign bit_mark = bit_pos | bit_neg;
    assign bpv      = bit_mark && any_mark_r && (bit_pos == last_pol_r);
    assign subst    = !ami_sel && bpv && hist_r == 2'b00;
    assign exz      = !ami_sel && !bit_mark && zero_cnt_r == (e1_rx_pkg::EXZ_RUN - 3'h1);
    assign cv_now   = ami_sel ? bpv : ((bpv && !subst) || exz);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_pol_r <= 1'b0;
            any_mark_r <= 1'b0;
            hist_r     <= 2'b00;
            zero_cnt_r <= 3'h0;
            data_dly_r <= 4'h0;
            cv_dly_r   <= 4'h0;
            dr_pos_r   <= 1'b0;
            dr_neg_r   <= 1'b0;
        end else if (clk_en && bit_tick) begin
            dr_pos_r <= bit_pos;
            dr_neg_r <= bit_neg;
            hist_r   <= {hist_r[0], bit_mark};
            if (bit_mark) begin
                last_pol_r <= bit_pos;
                any_mark_r <= 1'b1;
                zero_cnt_r <= 3'h0;
            end else if (zero_cnt_r != e1_rx_pkg::EXZ_RUN) begin
                zero_cnt_r <= zero_cnt_r + 3'h1;
            end
            data_dly_r <= subst ? 4'h0 : {data_dly_r[2:0], bit_mark};
            cv_dly_r   <= {cv_dly_r[2:0], cv_now};
        end
    end

    // ****************************************************************
    // Loss and alarm detection
    // ****************************************************************
    logic       los;
    logic [8:0] blk_cnt_r;
    logic [9:0] blk_zeros_r;
    logic       prev_low_r;
    logic       ais_r;
    logic       blk_low;

    e1_los_detect u_los (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .bit_tick    (bit_tick),
        .mark        (bit_mark),
        .etsi_select (cfg.host_mode && cfg.los_etsi_select),
        .los_r       (los)
    );

    assign blk_low = (blk_zeros_r + 10'(!bit_mark)) < e1_rx_pkg::AIS_MIN_ZEROS;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blk_cnt_r   <= 9'h000;
            blk_zeros_r <= 10'h000;
            prev_low_r  <= 1'b0;
            ais_r       <= 1'b0;
        end else if (clk_en && bit_tick) begin
            blk_cnt_r <= blk_cnt_r + 9'h001;
            if (blk_cnt_r == e1_rx_pkg::AIS_BLOCK_LAST) begin
                blk_zeros_r <= 10'h000;
                prev_low_r  <= blk_low;
                if (cfg.host_mode && cfg.los_etsi_select) begin
                    ais_r <= blk_low;
                end else if (blk_low == prev_low_r) begin
                    ais_r <= blk_low;
                end
            end else begin
                blk_zeros_r <= blk_zeros_r + 10'(!bit_mark);
            end
        end
    end

    // ****************************************************************
    // Status and enabled change events
    // ****************************************************************
    e1_rx_pkg::status_s status_nxt;

    always_comb begin
        status_nxt.los = los;
        status_nxt.ais = ais_r && cfg.host_mode;
        status_nxt.cv  = cv_dly_r[3];
        status_nxt.exz = exz;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status     <= '0;
            status_evt <= '0;
        end else if (clk_en) begin
            status     <= status_nxt;
            status_evt <= (status_nxt ^ status) & irq_enable;
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    logic rclk_cr;
    logic recovering;
    logic ais_fill;

    assign rclk_cr    = cfg.edge_polarity_select ? phase_r[3] : !phase_r[3];
    assign recovering = mode_r != e1_rx_pkg::MODE_DR_RAW && mode_r != e1_rx_pkg::MODE_PD;
    assign ais_fill   = los && cfg.alarm_ones_enable && mode_r != e1_rx_pkg::MODE_PD;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_pos_rail        <= 1'b0;
            rx_neg_rail        <= 1'b0;
            rx_recovered_clock <= 1'b0;
            rx_single_data     <= 1'b0;
            violation_flag_out <= 1'b0;
        end else if (clk_en) begin
            case (mode_r)
                e1_rx_pkg::MODE_SR1, e1_rx_pkg::MODE_SR2: begin
                    rx_single_data     <= data_dly_r[3];
                    violation_flag_out <= cv_dly_r[3];
                    rx_pos_rail        <= data_dly_r[3];
                    rx_neg_rail        <= cv_dly_r[3];
                    rx_recovered_clock <= rclk_cr;
                end
                e1_rx_pkg::MODE_DR_CR: begin
                    rx_single_data     <= 1'b0;
                    violation_flag_out <= 1'b0;
                    rx_pos_rail        <= dr_pos_r;
                    rx_neg_rail        <= dr_neg_r;
                    rx_recovered_clock <= rclk_cr;
                end
                e1_rx_pkg::MODE_DR_RAW: begin
                    rx_single_data     <= 1'b0;
                    violation_flag_out <= 1'b0;
                    rx_pos_rail        <= pos_s ^ !cfg.edge_polarity_select;
                    rx_neg_rail        <= neg_s ^ !cfg.edge_polarity_select;
                    rx_recovered_clock <= pos_s ^ neg_s;
                end
                default: begin
                    rx_single_data     <= 1'b0;
                    violation_flag_out <= 1'b0;
                    rx_pos_rail        <= 1'b0;
                    rx_neg_rail        <= 1'b0;
                    rx_recovered_clock <= 1'b0;
                end
            endcase
            if (ais_fill) begin
                rx_pos_rail        <= 1'b1;
                rx_neg_rail        <= 1'b1;
                rx_recovered_clock <= mclk_s;
                if (recovering) begin
                    rx_single_data <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            signal_loss_out <= 1'b0;
            rx_mode         <= e1_rx_pkg::MODE_DR_CR;
        end else if (clk_en) begin
            signal_loss_out <= los;
            rx_mode         <= mode_r;
        end
    end

endmodule // e1_rx_channel

// >>> core/e1_rx_pkg.sv
// Constants, modes and carrier types for the E1 receive channel.
package e1_rx_pkg;

    // ****************************************************************
    // Timing counts
    // ****************************************************************
    localparam int unsigned CLK_RATE_KHZ   = 100000;
    localparam int unsigned OS_RATE_KHZ    = 32768;
    localparam logic [15:0] OS_INC         =
        16'((64'(OS_RATE_KHZ) * 64'h10000) / 64'(CLK_RATE_KHZ));
    localparam logic [3:0]  SAMPLE_PHASE   = 4'h8;
    localparam logic [3:0]  REALIGN_PHASE  = 4'h1;
    localparam logic [4:0]  SR1_HIGH_LIMIT = 5'h10;
    localparam logic [4:0]  SR1_CNT_MAX    = 5'h11;
    localparam logic [7:0]  MCLK_TIMEOUT   = 8'h40;

    // ****************************************************************
    // Loss, alarm and error thresholds
    // ****************************************************************
    localparam logic [11:0] LOS_G775_ZEROS = 12'h020;
    localparam logic [11:0] LOS_ETSI_ZEROS = 12'h800;
    localparam logic [5:0]  LOS_CLR_MARKS  = 6'h04;
    localparam logic [11:0] LOS_RUN_LIMIT  = 12'h010;
    localparam logic [5:0]  LOS_WIN_BITS   = 6'h20;
    localparam logic [8:0]  AIS_BLOCK_LAST = 9'h1FF;
    localparam logic [9:0]  AIS_MIN_ZEROS  = 10'h003;
    localparam logic [2:0]  EXZ_RUN        = 3'h4;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [4:0] {
        MODE_SR1    = 5'h01,
        MODE_SR2    = 5'h02,
        MODE_DR_CR  = 5'h04,
        MODE_DR_RAW = 5'h08,
        MODE_PD     = 5'h10
    } rx_mode_e;

    typedef struct packed {
        logic host_mode;
        logic channel_raw_slice_bit;
        logic channel_single_rail_bit;
        logic global_ami_select;
        logic channel_ami_select;
        logic edge_polarity_select;
        logic los_etsi_select;
        logic alarm_ones_enable;
    } chan_cfg_s;

    typedef struct packed {
        logic los;
        logic ais;
        logic cv;
        logic exz;
    } status_s;

endpackage

// >>> testbench/e1_framer_model.sv
// Framer-side model of the transmit negative rail and its line clock.
module e1_framer_model (
    input  wire logic run,
    input  wire logic hold_high,
    output logic      tx_line_clock,
    output logic      tx_neg_rail
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tx_line_clock = 1'h0;
        tx_neg_rail = 1'h0;
        #1.7;
        forever begin
            #3;
            if (run) tx_line_clock = ~tx_line_clock;
        end
    end
    // The rail moves on the rising edge so it is settled at the falling one.
    always @(posedge tx_line_clock) tx_neg_rail <= hold_high | ~tx_neg_rail;
endmodule // e1_framer_model

// >>> testbench/e1_rx_channel_bench.sv
// Self-checking bench of the E1 receive channel.
module e1_rx_channel_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk, sys_rst, mclk, sp, sn, pol, seen;
    logic                 run, hold, tclk, tneg, pos, neg, cv, los;
    logic [1:0]           msel;
    logic [4:0]           mcnt;
    e1_rx_pkg::chan_cfg_s cfg;
    e1_rx_pkg::status_s   ien;
    e1_rx_pkg::rx_mode_e  mode;
    int                   n_errors, compares;
    e1_rx_channel dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'h1), .mclk(mclk),
        .tx_line_clock(tclk), .tx_neg_rail(tneg), .rx_slice_pos(sp), .rx_slice_neg(sn),
        .cfg(cfg), .irq_enable(ien), .rx_pos_rail(pos), .rx_neg_rail(neg),
        .rx_recovered_clock(), .rx_single_data(), .violation_flag_out(cv),
        .signal_loss_out(los), .rx_mode(mode), .status(), .status_evt());
    e1_framer_model fm (.run(run), .hold_high(hold), .tx_line_clock(tclk), .tx_neg_rail(tneg));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Master clock near 2.048 MHz, or held at a level while msel is not zero.
    always @(negedge clk) begin
        mcnt <= (mcnt == 5'h17) ? 5'h00 : mcnt + 5'h01;
        mclk <= (msel == 2'h0) ? mclk ^ (mcnt == 5'h17) : msel[0];
    end
    always @(negedge clk) if (cv === 1'h1) seen <= 1'h1;
    task automatic check(input logic [4:0] exp, input logic [4:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // Sends line bits: kind 0 zeros, 1 ones, 2 random, 3 marks of one polarity.
    task automatic bits(input int n, input int kind);
        logic m;
        repeat (n) begin
            @(negedge clk);
            m = (kind == 2) ? 1'($urandom) : (kind != 0);
            pol = pol ^ (m && kind != 3);
            sp = m & pol;
            sn = m & ~pol;
            repeat (24) @(negedge clk);
            sp = 1'h0;
            sn = 1'h0;
            repeat (24) @(negedge clk);
        end
    endtask
    task automatic set_mode(input logic [1:0] ms, input logic h, input logic [7:0] c,
                            input logic [4:0] exp);
        @(negedge clk);
        msel = ms;
        hold = h;
        cfg = c;
        repeat (150) @(negedge clk);
        check(exp, mode);
        $display("mode test ends");
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(80166));
        {sys_rst, mclk, sp, sn, pol, seen, run, hold} = 8'h80;
        msel = 2'h0;
        mcnt = 5'h00;
        cfg = 8'h00;
        ien = 4'($urandom) | 4'h8;
        n_errors = 0;
        compares = 0;
        repeat (8) @(negedge clk);
        sys_rst = 1'h0;
        run = 1'h1;
        bits(40, 0);
        check(5'h01, 5'(los));
        cfg.alarm_ones_enable = 1'h1;
        repeat (10) @(negedge clk);
        check(5'h03, {3'h0, pos, neg});
        cfg.alarm_ones_enable = 1'h0;
        bits(40, 1);
        check(5'h00, 5'(los));
        $display("loss test ends");
        set_mode(2'h0, 1'h1, 8'h00, e1_rx_pkg::MODE_SR1);
        set_mode(2'h0, 1'h0, 8'h00, e1_rx_pkg::MODE_DR_CR);
        set_mode(2'h1, 1'h0, 8'hA0, e1_rx_pkg::MODE_DR_RAW);
        set_mode(2'h2, 1'h0, 8'h00, e1_rx_pkg::MODE_PD);
        set_mode(2'h0, 1'h0, 8'hC0, e1_rx_pkg::MODE_DR_RAW);
        check(5'h03, {3'h0, pos, neg});
        cfg.edge_polarity_select = 1'h1;
        repeat (10) @(negedge clk);
        check(5'h00, {3'h0, pos, neg});
        bits(20, 2);
        set_mode(2'h0, 1'h0, 8'hA8, e1_rx_pkg::MODE_SR2);
        bits(30, 2);
        seen = 1'h0;
        bits(20, 2);
        check(5'h00, 5'(seen));
        bits(4, 3);
        repeat (300) @(negedge clk);
        check(5'h01, 5'(seen));
        set_mode(2'h0, 1'h0, 8'hA0, e1_rx_pkg::MODE_SR2);
        seen = 1'h0;
        bits(1, 1);
        bits(10, 0);
        check(5'h01, 5'(seen));
        set_mode(2'h0, 1'h1, 8'h10, e1_rx_pkg::MODE_SR1);
        seen = 1'h0;
        bits(1, 1);
        bits(10, 0);
        check(5'h00, 5'(seen));
        $display("violation test ends");
        report_and_stop();
    end
endmodule // e1_rx_channel_bench

// >>> testbench/e1_rx_chk.sv
// Port checker of the E1 receive channel.
module e1_rx_chk (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire e1_rx_pkg::chan_cfg_s cfg,
    input wire e1_rx_pkg::status_s   irq_enable,
    input wire logic                 rx_pos_rail,
    input wire logic                 rx_neg_rail,
    input wire logic                 rx_recovered_clock,
    input wire logic                 rx_single_data,
    input wire logic                 violation_flag_out,
    input wire logic                 signal_loss_out,
    input wire e1_rx_pkg::rx_mode_e  rx_mode,
    input wire e1_rx_pkg::status_s   status,
    input wire e1_rx_pkg::status_s   status_evt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    e1_rx_pkg::rx_mode_e m1_r;
    e1_rx_pkg::rx_mode_e m2_r;
    logic                steady;
    logic                single;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            m1_r <= e1_rx_pkg::MODE_PD;
            m2_r <= e1_rx_pkg::MODE_SR1;
        end else begin
            m1_r <= rx_mode;
            m2_r <= m1_r;
        end
    end
    assign steady = rx_mode == m1_r && m1_r == m2_r;
    assign single = rx_mode == e1_rx_pkg::MODE_SR1 || rx_mode == e1_rx_pkg::MODE_SR2;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_mode_one_hot: assert property ($onehot(rx_mode))
        else $error("mode not one-hot");
    a_single_mirror: assert property (steady && single && !cfg.alarm_ones_enable
        && !$past(cfg.alarm_ones_enable) |->
        rx_pos_rail == rx_single_data && rx_neg_rail == violation_flag_out)
        else $error("single rail pins not mirrored");
    a_dual_no_violation: assert property (steady && !single |-> !violation_flag_out)
        else $error("violation outside single rail");
    a_raw_xor_clock: assert property (steady && rx_mode == e1_rx_pkg::MODE_DR_RAW
        && !cfg.alarm_ones_enable && !$past(cfg.alarm_ones_enable)
        |-> rx_recovered_clock == (rx_pos_rail ^ rx_neg_rail))
        else $error("raw clock not rail xor");
    a_alarm_all_ones: assert property (steady && rx_mode != e1_rx_pkg::MODE_PD
        && $past(signal_loss_out, 2) && $past(cfg.alarm_ones_enable, 2) && signal_loss_out
        && cfg.alarm_ones_enable |-> rx_pos_rail && rx_neg_rail)
        else $error("rails not all ones in loss");
    a_powerdown_quiet: assert property (steady && rx_mode == e1_rx_pkg::MODE_PD |->
        !(rx_pos_rail || rx_neg_rail || rx_recovered_clock || rx_single_data))
        else $error("outputs active in power down");
    a_event_gated: assert property ((status_evt & ~irq_enable & ~$past(irq_enable)) == 4'h0)
        else $error("event from disabled source");
    a_loss_status: assert property ($rose(signal_loss_out) |-> ##[0:2] status.los)
        else $error("loss pin without loss status");
    a_loss_event: assert property ($changed(status.los) && $past(irq_enable.los)
        |-> status_evt.los) else $error("loss change without event");
    c_single_one: cover property (rx_mode == e1_rx_pkg::MODE_SR1);
    c_raw_slice: cover property (rx_mode == e1_rx_pkg::MODE_DR_RAW);
    c_loss_seen: cover property ($rose(signal_loss_out));
    c_loss_event: cover property (status_evt.los);
endmodule // e1_rx_chk

bind e1_rx_channel e1_rx_chk chk (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
    .irq_enable(irq_enable), .rx_pos_rail(rx_pos_rail), .rx_neg_rail(rx_neg_rail),
    .rx_recovered_clock(rx_recovered_clock), .rx_single_data(rx_single_data),
    .violation_flag_out(violation_flag_out), .signal_loss_out(signal_loss_out),
    .rx_mode(rx_mode), .status(status), .status_evt(status_evt));
